// ---- rtl/bcd_pkg.sv ----
// Shared constants of the brake and command direction controller.
package bcd_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on APB).
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_BRK_SEL  = 8'h00;
  localparam logic [7:0] OFF_RES_OHM  = 8'h04;
  localparam logic [7:0] OFF_RES_PWR  = 8'h08;
  localparam logic [7:0] OFF_DECAY    = 8'h0C;
  localparam logic [7:0] OFF_INV_MASK = 8'h10;
  localparam logic [7:0] OFF_POS_SRC  = 8'h14;
  localparam logic [7:0] OFF_STATUS   = 8'h18;
  localparam logic [7:0] OFF_HEAT     = 8'h1C;
  localparam logic [7:0] OFF_CTRL     = 8'h20;

  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_BRK_SEL  = 16'h0002;
  localparam logic [15:0] RST_RES_OHM  = 16'h0000;
  localparam logic [15:0] RST_RES_PWR  = 16'h0000;
  localparam logic [15:0] RST_DECAY    = 16'h0032;
  localparam logic [15:0] RST_INV_MASK = 16'h0000;
  localparam logic [15:0] RST_POS_SRC  = 16'h0000;
  localparam logic [15:0] RST_CTRL     = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int INV_POS_BIT  = 0;
  localparam int INV_SPD_BIT  = 1;
  localparam int INV_TRQ_BIT  = 2;
  localparam int CTRL_V380    = 0;
  localparam int ST_BRAKE     = 0;
  localparam int ST_OVP       = 1;
  localparam int ST_HEAT_FULL = 2;
  localparam int ST_INHIBIT   = 3;

  // ----------------------------------------------------------------
  // Braking start modes and position sources.
  // ----------------------------------------------------------------
  localparam logic [15:0] BRK_NEVER = 16'h0000;
  localparam logic [15:0] BRK_DECEL = 16'h0001;
  localparam logic [15:0] BRK_ANY   = 16'h0002;
  localparam logic [15:0] BRK_REGEN = 16'h0003;
  localparam logic [15:0] SRC_PULSE = 16'h0000;
  localparam logic [15:0] SRC_PLAN  = 16'h0001;
  localparam logic [15:0] SRC_SWTCH = 16'h0002;
  localparam logic [15:0] SRC_ENC2  = 16'h0003;
  localparam logic [15:0] SRC_PADD  = 16'h0004;
  localparam logic [15:0] SRC_LABEL = 16'h0005;
  localparam logic [15:0] SRC_SINE  = 16'h0006;

  // ----------------------------------------------------------------
  // Bus voltage limits in volts and heat model timing.
  // ----------------------------------------------------------------
  localparam logic [15:0] VBUS_ON_220 = 16'd380;
  localparam logic [15:0] VBUS_ON_380 = 16'd680;
  localparam logic [15:0] DECAY_MAX   = 16'd100;
  localparam int          CLK_MHZ     = 200;
  localparam int          DECAY_MS    = 10000;
  localparam int          DECAY_STEPS = 100;
  localparam int          TICK_CYC    = DECAY_MS * 1000 / DECAY_STEPS
                                        * CLK_MHZ;
  localparam logic [15:0] HEAT_MAX    = 16'd10000;

endpackage

// ---- rtl/bcd_sync.sv ----
// Three-stage input synchroniser with agreement filter per bit.
`timescale 1ns/1ps
module bcd_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ----------------------------------------------------------------
  // Per-bit chain; the first stage feeds only the second.
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      // A change is taken only once stages two and three agree.
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1   <= 1'b0;
          s2   <= 1'b0;
          s3   <= 1'b0;
          q[i] <= 1'b0;
        end else if (ce) begin
          s1 <= d[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            q[i] <= s3;
          end
        end
      end
    end
  endgenerate

endmodule

// ---- rtl/bcd_top.sv ----
// Dynamic brake control, resistor heat model and command direction.
`timescale 1ns/1ps
module bcd_top #(
  parameter int          CMD_W      = 32,
  parameter bit          PULSE_PORT = 1'b0,
  parameter int          TICK_CYC   = bcd_pkg::TICK_CYC,
  parameter logic [15:0] HEAT_RISE  = 16'd200,
  parameter logic [15:0] OVP_220    = 16'd420,
  parameter logic [15:0] OVP_380    = 16'd760
) (
  input  wire logic             CORE_CLK,
  input  wire logic             RST_N,
  input  wire logic             CE,
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [7:0]       PADDR,
  input  wire logic [31:0]      PWDATA,
  output logic      [31:0]      PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  input  wire logic [15:0]      VBUS,
  input  wire logic             DECEL,
  input  wire logic             REGEN,
  input  wire logic             SRC_SWITCH_IN,
  input  wire logic             POS_INHIBIT_IN,
  input  wire logic             POS_INVERT_IN,
  input  wire logic [CMD_W-1:0] PULSE_CMD,
  input  wire logic [CMD_W-1:0] PLAN_CMD,
  input  wire logic [CMD_W-1:0] ENC2_CMD,
  input  wire logic [CMD_W-1:0] LABEL_CMD,
  input  wire logic [CMD_W-1:0] SINE_CMD,
  input  wire logic [CMD_W-1:0] SPD_CMD,
  input  wire logic [CMD_W-1:0] TRQ_CMD,
  output logic      [CMD_W-1:0] POS_OUT,
  output logic      [CMD_W-1:0] SPD_OUT,
  output logic      [CMD_W-1:0] TRQ_OUT,
  output logic                  BRAKE_ON,
  output logic                  OVP_FAULT
);

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  logic [15:0]      brake_start_select;
  logic [15:0]      brake_resistor_ohms;
  logic [15:0]      brake_resistor_max_power;
  logic [15:0]      brake_heat_decay_coeff;
  logic [15:0]      command_invert_mask;
  logic [15:0]      position_cmd_source;
  logic [15:0]      ctrl;
  logic [15:0]      heat;
  logic [31:0]      tick_cnt;
  logic             tick;
  logic [2:0]       in_sync;
  logic             source_switch_input;
  logic             position_cmd_inhibit_input;
  logic             position_cmd_invert_input;
  logic             wr_en;
  logic             rd_setup;
  logic [31:0]      next_rdata;
  logic             next_err;
  logic [15:0]      on_lim;
  logic [15:0]      ovp_lim;
  logic             over;
  logic             next_brake;
  logic             ovp_clr;
  logic [CMD_W-1:0] pulse;
  logic [CMD_W-1:0] pos_sel;
  logic             pos_neg;
  logic [15:0]      status;

  // ----------------------------------------------------------------
  // Pin inputs pass the three-stage synchroniser.
  // ----------------------------------------------------------------
  bcd_sync #(
    .W (3)
  ) u_sync (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .d     ({POS_INVERT_IN, POS_INHIBIT_IN, SRC_SWITCH_IN}),
    .q     (in_sync)
  );
  assign source_switch_input        = in_sync[0];
  assign position_cmd_inhibit_input = in_sync[1];
  assign position_cmd_invert_input  = in_sync[2];

  // ----------------------------------------------------------------
  // APB slave. Zero wait states while enabled; a frozen block holds
  // the transfer in its access phase so no write is lost.
  // ----------------------------------------------------------------
  assign PREADY   = CE;
  assign wr_en    = PSEL && PENABLE && PWRITE && CE;
  assign rd_setup = PSEL && !PENABLE && CE;
  assign ovp_clr  = wr_en && (PADDR == bcd_pkg::OFF_STATUS)
                    && PWDATA[bcd_pkg::ST_OVP];

  // Status word assembled from live block state.
  assign status = {12'h000, position_cmd_inhibit_input,
                   heat == bcd_pkg::HEAT_MAX, OVP_FAULT, BRAKE_ON};

  // Read mux; unmapped addresses answer zero with an error.
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (PADDR == bcd_pkg::OFF_BRK_SEL) begin
      next_rdata[15:0] = brake_start_select;
    end else if (PADDR == bcd_pkg::OFF_RES_OHM) begin
      next_rdata[15:0] = brake_resistor_ohms;
    end else if (PADDR == bcd_pkg::OFF_RES_PWR) begin
      next_rdata[15:0] = brake_resistor_max_power;
    end else if (PADDR == bcd_pkg::OFF_DECAY) begin
      next_rdata[15:0] = brake_heat_decay_coeff;
    end else if (PADDR == bcd_pkg::OFF_INV_MASK) begin
      next_rdata[15:0] = command_invert_mask;
    end else if (PADDR == bcd_pkg::OFF_POS_SRC) begin
      next_rdata[15:0] = position_cmd_source;
    end else if (PADDR == bcd_pkg::OFF_STATUS) begin
      next_rdata[15:0] = status;
    end else if (PADDR == bcd_pkg::OFF_HEAT) begin
      next_rdata[15:0] = heat;
    end else if (PADDR == bcd_pkg::OFF_CTRL) begin
      next_rdata[15:0] = ctrl;
    end else begin
      next_err = 1'b1;
    end
  end

  // Read data and error are latched in the setup cycle.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (rd_setup) begin
      PRDATA  <= next_rdata;
      PSLVERR <= next_err;
    end
  end

  // Settings registers; a write acts from the next cycle on.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      brake_start_select       <= bcd_pkg::RST_BRK_SEL;
      brake_resistor_ohms      <= bcd_pkg::RST_RES_OHM;
      brake_resistor_max_power <= bcd_pkg::RST_RES_PWR;
      brake_heat_decay_coeff   <= bcd_pkg::RST_DECAY;
      command_invert_mask      <= bcd_pkg::RST_INV_MASK;
      position_cmd_source      <= bcd_pkg::RST_POS_SRC;
      ctrl                     <= bcd_pkg::RST_CTRL;
    end else if (wr_en) begin
      if (PADDR == bcd_pkg::OFF_BRK_SEL) begin
        brake_start_select <= PWDATA[15:0];
      end else if (PADDR == bcd_pkg::OFF_RES_OHM) begin
        brake_resistor_ohms <= PWDATA[15:0];
      end else if (PADDR == bcd_pkg::OFF_RES_PWR) begin
        brake_resistor_max_power <= PWDATA[15:0];
      end else if (PADDR == bcd_pkg::OFF_DECAY) begin
        // Values above full scale are clipped to full scale.
        brake_heat_decay_coeff <= (PWDATA[15:0] > bcd_pkg::DECAY_MAX)
                                  ? bcd_pkg::DECAY_MAX : PWDATA[15:0];
      end else if (PADDR == bcd_pkg::OFF_INV_MASK) begin
        command_invert_mask <= PWDATA[15:0];
      end else if (PADDR == bcd_pkg::OFF_POS_SRC) begin
        position_cmd_source <= PWDATA[15:0];
      end else if (PADDR == bcd_pkg::OFF_CTRL) begin
        ctrl <= PWDATA[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Dynamic braking.
  // ----------------------------------------------------------------
  assign on_lim  = ctrl[bcd_pkg::CTRL_V380] ? bcd_pkg::VBUS_ON_380
                                            : bcd_pkg::VBUS_ON_220;
  assign ovp_lim = ctrl[bcd_pkg::CTRL_V380] ? OVP_380 : OVP_220;
  assign over    = VBUS > on_lim;

  // Mode gate on the overvoltage condition.
  always_comb begin
    case (brake_start_select)
      bcd_pkg::BRK_NEVER: next_brake = 1'b0;
      bcd_pkg::BRK_DECEL: next_brake = over && DECEL;
      bcd_pkg::BRK_ANY:   next_brake = over;
      bcd_pkg::BRK_REGEN: next_brake = over && REGEN;
      default:            next_brake = 1'b0;
    endcase
  end

  // Brake output registered so mode changes land on the next cycle.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      BRAKE_ON <= 1'b0;
    end else if (CE) begin
      BRAKE_ON <= next_brake;
    end
  end

  // Sticky overvoltage fault; a new event beats a clear.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      OVP_FAULT <= 1'b0;
    end else if (CE) begin
      if (VBUS > ovp_lim) begin
        OVP_FAULT <= 1'b1;
      end else if (ovp_clr) begin
        OVP_FAULT <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Resistor heat model. Heat rises while braking and falls by the
  // coefficient each tick, so 100 takes full heat to zero in 10 s.
  // ----------------------------------------------------------------
  assign tick = tick_cnt == 32'(TICK_CYC - 1);

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt <= 32'h0000_0000;
    end else if (CE) begin
      tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
    end
  end

  // Saturating heat accumulator; braking wins over decay.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      heat <= 16'h0000;
    end else if (CE && tick) begin
      if (BRAKE_ON) begin
        heat <= (bcd_pkg::HEAT_MAX - heat < HEAT_RISE)
                ? bcd_pkg::HEAT_MAX : heat + HEAT_RISE;
      end else if (heat > brake_heat_decay_coeff) begin
        heat <= heat - brake_heat_decay_coeff;
      end else begin
        heat <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Position command source. Without a pulse port the pulse path is
  // forced to zero and pulse-only sources fall back to the planner.
  // ----------------------------------------------------------------
  assign pulse = PULSE_PORT ? PULSE_CMD : '0;

  always_comb begin
    case (position_cmd_source)
      bcd_pkg::SRC_PULSE: begin
        pos_sel = PULSE_PORT ? pulse : PLAN_CMD;
      end
      bcd_pkg::SRC_PLAN: begin
        pos_sel = PLAN_CMD;
      end
      bcd_pkg::SRC_SWTCH: begin
        pos_sel = (source_switch_input || !PULSE_PORT)
                  ? PLAN_CMD : pulse;
      end
      bcd_pkg::SRC_ENC2: begin
        pos_sel = pulse + ENC2_CMD;
      end
      bcd_pkg::SRC_PADD: begin
        pos_sel = pulse + PLAN_CMD;
      end
      bcd_pkg::SRC_LABEL: begin
        pos_sel = LABEL_CMD;
      end
      bcd_pkg::SRC_SINE: begin
        pos_sel = SINE_CMD;
      end
      default: begin
        pos_sel = '0;
      end
    endcase
  end

  // Mask bit and invert input both negate; together they cancel.
  assign pos_neg = command_invert_mask[bcd_pkg::INV_POS_BIT]
                   ^ position_cmd_invert_input;

  // Commands sampled and negated in one cycle, then registered.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      POS_OUT <= '0;
      SPD_OUT <= '0;
      TRQ_OUT <= '0;
    end else if (CE) begin
      if (position_cmd_inhibit_input) begin
        POS_OUT <= '0;
      end else begin
        POS_OUT <= pos_neg ? -pos_sel : pos_sel;
      end
      SPD_OUT <= command_invert_mask[bcd_pkg::INV_SPD_BIT]
                 ? -SPD_CMD : SPD_CMD;
      TRQ_OUT <= command_invert_mask[bcd_pkg::INV_TRQ_BIT]
                 ? -TRQ_CMD : TRQ_CMD;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence apb_wr_s(logic [7:0] a);
    PSEL && PENABLE && PWRITE && PREADY && PADDR == a;
  endsequence

  sequence ovp_hit_s;
    CE && VBUS > ovp_lim;
  endsequence

  brake_220_on_a: assert property (
    CE && !ctrl[0] && brake_start_select == 16'h0002 && VBUS > 16'd380
    |=> BRAKE_ON)
    else $error("brake not on above 380 V");
  brake_380_on_a: assert property (
    CE && ctrl[0] && brake_start_select == 16'h0002 && VBUS <= 16'd680
    |=> !BRAKE_ON)
    else $error("brake on at or below 680 V");
  brake_mode_gate_a: assert property (
    CE && brake_start_select == 16'h0001
    |=> BRAKE_ON == $past(over && DECEL))
    else $error("decelerate mode gate wrong");
  brake_regen_a: assert property (
    CE && brake_start_select == 16'h0003 && !REGEN |=> !BRAKE_ON)
    else $error("brake on without regeneration");
  ovp_sticky_a: assert property (
    ovp_hit_s ##1 (CE && VBUS <= ovp_lim && !ovp_clr)[*2]
    |-> OVP_FAULT)
    else $error("overvoltage fault lost");
  heat_decay_a: assert property (
    CE && tick && !BRAKE_ON && heat > brake_heat_decay_coeff
    |=> heat == $past(heat) - $past(brake_heat_decay_coeff))
    else $error("heat decay step wrong");
  mask_write_a: assert property (
    apb_wr_s(bcd_pkg::OFF_INV_MASK)
    |=> command_invert_mask == $past(PWDATA[15:0]))
    else $error("invert mask write lost");
  spd_invert_a: assert property (
    CE && command_invert_mask[1] |=> SPD_OUT == -$past(SPD_CMD))
    else $error("speed not negated");
  trq_invert_a: assert property (
    CE && !command_invert_mask[2] |=> TRQ_OUT == $past(TRQ_CMD))
    else $error("torque changed without mask");
  pos_inhibit_a: assert property (
    CE && position_cmd_inhibit_input |=> POS_OUT == '0)
    else $error("position passed while inhibited");
  pos_invert_a: assert property (
    CE && !position_cmd_inhibit_input && position_cmd_source == 16'h0001
    && pos_neg |=> POS_OUT == -$past(PLAN_CMD))
    else $error("position not negated");

endmodule

// ---- verif/bcd_partner.sv ----
// Behavioural power stage, bus voltage sensing and motor state.
`timescale 1ns/1ps
module bcd_partner #(
  parameter int SLEW = 1000
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] tgt_v,
  input  wire logic        dec_i,
  input  wire logic        reg_i,
  output logic      [15:0] vbus,
  output logic             decel,
  output logic             regen
);
  // ------------------------------------------------------------
  // Bus voltage and motion state.
  // ------------------------------------------------------------
  // A small SLEW gives a slowly charging bus, like a real capacitor.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vbus  <= 16'h0000;
      decel <= 1'b0;
      regen <= 1'b0;
    end else begin
      decel <= dec_i;
      regen <= reg_i;
      if (int'(tgt_v) > int'(vbus) + SLEW)
        vbus <= vbus + 16'(SLEW);
      else if (int'(vbus) > int'(tgt_v) + SLEW)
        vbus <= vbus - 16'(SLEW);
      else
        vbus <= tgt_v;
    end
  end
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the brake and command direction controller.
`timescale 1ns/1ps
module testbench;
  // ------------------------------------------------------------
  // Signals and tables.
  // ------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, pos_o, spd_o, trq_o;
  logic        pready, pslverr, err, brake_on, ovp, decel, regen;
  logic [15:0] vbus;
  logic [15:0] tgt_v = 16'h0000;
  logic        dec_i = 1'b0;
  logic        reg_i = 1'b0;
  logic        sw_in = 1'b0;
  logic        inh_in = 1'b0;
  logic        inv_in = 1'b0;
  logic [31:0] spd = 32'h5;
  logic [31:0] trq = 32'hFFFF_FFF9;
  logic [31:0] cv [7] = '{32'h111, 32'h64, 32'h333, 32'h555, 32'h666,
                          32'h5, 32'h0};
  int          error_cnt = 0;
  int          tests_run = 0;
  localparam logic [7:0] OFFS [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
                                      8'h14};
  localparam logic [31:0] RSTV [6] = '{32'h2, 32'h0, 32'h0, 32'h32, 32'h0,
                                       32'h0};
  localparam logic [31:0] WRV [6] = '{32'hFFFF_0003, 32'h7FFF, 32'h7FFF,
                                      32'hC8, 32'h7, 32'h6};
  localparam logic [31:0] EXPV [6] = '{32'h3, 32'h7FFF, 32'h7FFF, 32'h64,
                                       32'h7, 32'h6};
  // Expected position per source; pulses count as zero here.
  localparam logic [31:0] SRCX [8] = '{32'h64, 32'h64, 32'h64, 32'h333,
                                       32'h64, 32'h555, 32'h666, 32'h0};

  always #2.5 clk = ~clk;

  bcd_partner plant (.clk(clk), .rst_n(rst_n), .tgt_v(tgt_v), .dec_i(dec_i),
                     .reg_i(reg_i), .vbus(vbus), .decel(decel),
                     .regen(regen));

  bcd_top #(.TICK_CYC(10)) dut (
    .CORE_CLK(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .VBUS(vbus),
    .DECEL(decel), .REGEN(regen), .SRC_SWITCH_IN(sw_in),
    .POS_INHIBIT_IN(inh_in), .POS_INVERT_IN(inv_in), .PULSE_CMD(cv[0]),
    .PLAN_CMD(cv[1]), .ENC2_CMD(cv[2]), .LABEL_CMD(cv[3]),
    .SINE_CMD(cv[4]), .SPD_CMD(spd), .TRQ_CMD(trq), .POS_OUT(pos_o),
    .SPD_OUT(spd_o), .TRQ_OUT(trq_o), .BRAKE_ON(brake_on),
    .OVP_FAULT(ovp));

  // ------------------------------------------------------------
  // Tasks.
  // ------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the wait for the answer is bounded.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      error_cnt++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits for registered outputs and the pin synchronisers to settle.
  task automatic settle(input int n = 4);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, OFFS[i], 32'h0);
      chk(rd, RSTV[i]);
      apb(1'b1, OFFS[i], WRV[i]);
      apb(1'b0, OFFS[i], 32'h0);
      chk(rd, EXPV[i]);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // Every braking mode against every motion state at 381 V.
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 8'h00, 32'(m));
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        tgt_v <= 16'd381;
        dec_i <= k[0];
        reg_i <= k[1];
        settle();
        chk(32'(brake_on), 32'((m == 2) || (m == 1 && k[0]) ||
            (m == 3 && k[1])));
      end
    end
    // Thresholds of both variants, exactly at and one volt above.
    apb(1'b1, 8'h00, 32'h2);
    for (int j = 0; j < 4; j++) begin
      apb(1'b1, 8'h20, 32'(j / 2));
      @(posedge clk);
      tgt_v <= ((j < 2) ? 16'd380 : 16'd680) + 16'(j % 2);
      settle();
      chk(32'(brake_on), 32'(j % 2));
    end
    // Overvoltage fault is sticky until software clears it; the bus is
    // brought to the limit first so the variant switch cannot set it.
    @(posedge clk);
    tgt_v <= 16'd420;
    apb(1'b1, 8'h20, 32'h0);
    settle();
    chk(32'(ovp), 32'h0);
    @(posedge clk);
    tgt_v <= 16'd421;
    settle();
    chk(32'(ovp), 32'h1);
    @(posedge clk);
    tgt_v <= 16'd0;
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(rd[1]), 32'h1);
    apb(1'b1, 8'h18, 32'h2);
    settle();
    chk(32'(ovp), 32'h0);
    // Heat fills with decay off, then empties in 100 ticks at 100 %.
    apb(1'b1, 8'h0C, 32'h0);
    @(posedge clk);
    tgt_v <= 16'd381;
    settle(600);
    apb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'd10000);
    // Status shows braking and full heat, no fault, no inhibit.
    apb(1'b0, 8'h18, 32'h0);
    chk({28'h0, rd[3:0]}, 32'h5);
    @(posedge clk);
    tgt_v <= 16'd0;
    apb(1'b1, 8'h0C, 32'd100);
    settle(400);
    apb(1'b0, 8'h1C, 32'h0);
    chk(32'(rd > 32'd5500 && rd < 32'd6500), 32'h1);
    settle(700);
    apb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0);
    // Direction masks on all three commands.
    apb(1'b1, 8'h14, 32'h1);
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, 8'h10, 32'(m));
      settle();
      chk(pos_o, m[0] ? -32'd100 : 32'd100);
      chk(spd_o, m[1] ? -32'd5 : 32'd5);
      chk(trq_o, m[2] ? 32'd7 : -32'd7);
    end
    // Every source code, out-of-range included.
    apb(1'b1, 8'h10, 32'h0);
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, 8'h14, 32'(s));
      settle();
      chk(pos_o, SRCX[s]);
    end
    apb(1'b1, 8'h14, 32'h2);
    @(posedge clk);
    sw_in <= 1'b1;
    settle(8);
    chk(pos_o, 32'h64);
    // Inhibit and invert pins.
    @(posedge clk);
    inh_in <= 1'b1;
    settle(8);
    chk(pos_o, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(rd[3]), 32'h1);
    @(posedge clk);
    inh_in <= 1'b0;
    inv_in <= 1'b1;
    settle(8);
    chk(pos_o, -32'd100);
    apb(1'b1, 8'h10, 32'h1);
    settle();
    chk(pos_o, 32'd100);
    // A low enable freezes all state and holds the bus answer low.
    @(posedge clk);
    ce <= 1'b0;
    inv_in <= 1'b0;
    settle(8);
    chk(32'(pready), 32'h0);
    chk(pos_o, 32'd100);
    @(posedge clk);
    ce <= 1'b1;
    settle(8);
    chk(pos_o, -32'd100);
    summarize();
  end
endmodule
